/* rtl/ivt_pkg.sv */
/*
 * Constants for the three-channel interval counter with pacer cascade.
 * Assumes a byte-wide register port at offsets 12..15 and one system clock.
 */
// Contract
// [R1] Mode 5 starts on trigger rising edge, output low one clock at terminal count.
// [R2] Host writes control byte before loading a channel's initial count.
// [R3] Each control byte applies to the channel its select field names.
// [R4] Access types low, high, low-then-high; host pairs accesses and tracks order.
// [R5] Read-back exposes count, mode, output level and null-count for chosen channels.
// [R6] Read-back with count latch bit low latches count of every chosen channel.
// [R7] Read-back with status bit low latches status; next channel read returns it.
// [R8] Access type zero copies live count into a 16-bit hold register.
// [R9] Read-back count latching may cover several channels in one write.
// [R10] After a count latch the next read returns the latched value.
// [R11] Counters 1 and 2 cascade; trigger rate is base clock over divisor product.
// [R12] Pacer base clock selectable between 1 MHz and 10 MHz statically.
// [R13] Software writes 76h to set counter 1 square wave, low-then-high.
// [R14] Software loads counter 1 divisor 2..65535, low byte then high byte.
// [R15] Software writes B6h to set counter 2 square wave, low-then-high.
// [R16] Software loads counter 2 divisor 2..65535, low byte then high byte.
// [R17] Select codes 00, 01, 10 pick counters 0..2; 11 means read-back.
// [R18] Counter data at offsets 12..14, control word at offset 15.
// [R19] Square wave odd N: high (N+1)/2 clocks, low (N-1)/2 clocks.
// [R20] Status byte: output, null count, access type, mode, counting type.
// [R21] Trigger inputs synchronised and detected as low-to-high edges.
// [R22] Counter 1 output clocks counter 2; counter 2 output is conversion trigger.
package ivt_pkg;
    localparam logic [3:0] OFS_CNT0  = 4'hC;
    localparam logic [3:0] OFS_CNT1  = 4'hD;
    localparam logic [3:0] OFS_CNT2  = 4'hE;
    localparam logic [3:0] OFS_CTRL  = 4'hF;
    localparam int SEL_POS   = 6;
    localparam int ACC_POS   = 4;
    localparam int MODE_POS  = 1;
    localparam int BCD_POS   = 0;
    localparam int RB_CNT_N  = 5;
    localparam int RB_STA_N  = 4;
    localparam int RB_TGT    = 1;
    localparam logic [1:0] SEL_READBACK = 2'h3;
    localparam logic [1:0] ACC_LATCH = 2'h0;
    localparam logic [1:0] ACC_LO    = 2'h1;
    localparam logic [1:0] ACC_HI    = 2'h2;
    localparam logic [1:0] ACC_LOHI  = 2'h3;
    localparam logic [2:0] MODE_HWSTROBE = 3'h5;
    localparam logic [5:0] CFG_RESET = 6'h00;
    localparam int CLK_HZ       = 10000000;
    localparam int BASE_FAST_HZ = 10000000;
    localparam int BASE_SLOW_HZ = 1000000;
    localparam logic [3:0] SLOW_DIV = 4'(CLK_HZ / BASE_SLOW_HZ - 1);
    localparam logic [3:0] FAST_DIV = 4'(CLK_HZ / BASE_FAST_HZ - 1);
endpackage

/* rtl/ivt_channel.sv */
/*
 * One 16-bit counting channel: modes 0..5, binary counting, latches.
 * Assumes the parent decodes the port and gives a one-cycle count tick.
 */
`timescale 1ns/100ps
`default_nettype none
module ivt_channel (
    input  wire logic       clk,       // System clock.
    input  wire logic       rst_n,     // Synchronised reset, active low.
    input  wire logic       tick,      // Count edge of this channel.
    input  wire logic       gate_rise, // Synchronised gate rising edge.
    input  wire logic       gate_lvl,  // Synchronised gate level.
    input  wire logic       cfg_we,    // Control byte for this channel.
    input  wire logic [5:0] cfg_in,    // Access, mode and counting type.
    input  wire logic       cnt_latch, // Count latch request.
    input  wire logic       sta_latch, // Status latch request.
    input  wire logic       wr,        // Data write strobe.
    input  wire logic       rd,        // Data read strobe.
    input  wire logic [7:0] wdata,     // Write data.
    output logic      [7:0] rdata,     // Read data, combinational.
    output logic            out        // Channel output.
);
    logic [5:0]  cfg_ff;
    logic [15:0] init_ff, cnt_ff, hold_ff;
    logic [7:0]  lo_ff, sta_ff;
    logic        wr_hi_ff, rd_hi_ff, held_ff, sta_v_ff, null_ff, armed_ff, out_ff, load_ff;
    logic        half_ff;

    wire [1:0] acc  = cfg_ff[5:4];
    wire [2:0] mode = cfg_ff[3:1];
    wire       sq   = mode[1] & mode[0];
    wire       rate = mode[1] & ~mode[0];
    wire [15:0] n_eff = (init_ff == 16'h0000) ? 16'hFFFF : init_ff;
    wire [15:0] rd_word = held_ff ? hold_ff : cnt_ff; // [R10]
    wire        rd_hi = (acc == ivt_pkg::ACC_HI) | ((acc == ivt_pkg::ACC_LOHI) & rd_hi_ff);
    wire        wr_done = wr & ((acc != ivt_pkg::ACC_LOHI) | wr_hi_ff);
    // Square wave: high phase first loads (N+1)/2 and counts, each phase measured in clocks.
    // Widened so that a count of 65535 does not wrap the half-period to zero.
    wire [16:0] sq_sum = {1'b0, n_eff} + 17'h00001;
    wire [15:0] sq_hi = sq_sum[16:1]; // [R19]
    wire [15:0] sq_lo = n_eff >> 1; // [R19]
    wire        tc = (cnt_ff == 16'h0001);
    wire        hw_start = (mode == ivt_pkg::MODE_HWSTROBE) & gate_rise & ~null_ff; // [R1] [R21]

    assign rdata = sta_v_ff ? sta_ff : (rd_hi ? rd_word[15:8] : rd_word[7:0]); // [R7]
    assign out = out_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ff <= ivt_pkg::CFG_RESET; init_ff <= 16'h0000; cnt_ff <= 16'h0000;
            hold_ff <= 16'h0000; lo_ff <= 8'h00; sta_ff <= 8'h00; wr_hi_ff <= 1'b0;
            rd_hi_ff <= 1'b0; held_ff <= 1'b0; sta_v_ff <= 1'b0; null_ff <= 1'b1;
            armed_ff <= 1'b0; out_ff <= 1'b1; load_ff <= 1'b0; half_ff <= 1'b0;
        end else begin
            if (cfg_we) begin // [R3]
                cfg_ff <= cfg_in; wr_hi_ff <= 1'b0; rd_hi_ff <= 1'b0; held_ff <= 1'b0;
                null_ff <= 1'b1; armed_ff <= 1'b0; load_ff <= 1'b0;
                out_ff <= (cfg_in[3:1] != 3'h0);
            end
            if (cnt_latch && !held_ff) begin // [R6] [R8] [R9]
                hold_ff <= cnt_ff; held_ff <= 1'b1;
            end
            if (sta_latch && !sta_v_ff) begin // [R5] [R20]
                sta_ff <= {out_ff, null_ff, cfg_ff}; sta_v_ff <= 1'b1;
            end
            if (rd) begin // [R4]
                if (sta_v_ff) sta_v_ff <= 1'b0;
                else begin
                    if (acc == ivt_pkg::ACC_LOHI) rd_hi_ff <= ~rd_hi_ff;
                    // A release only clears a held latch, so a latch taken in this cycle stays.
                    if (held_ff && (acc != ivt_pkg::ACC_LOHI || rd_hi_ff)) held_ff <= 1'b0;
                end
            end
            if (hw_start) begin
                cnt_ff <= n_eff; armed_ff <= 1'b1; // [R1]
            end else if (tick && !cfg_we) begin
                if (load_ff && !(mode == ivt_pkg::MODE_HWSTROBE) && (!(sq|rate) || !armed_ff)) begin
                    cnt_ff <= sq ? sq_hi : n_eff; null_ff <= 1'b0; load_ff <= 1'b0;
                    armed_ff <= 1'b1; out_ff <= (mode != 3'h0); half_ff <= 1'b1;
                end else if (mode == ivt_pkg::MODE_HWSTROBE && load_ff) begin
                    null_ff <= 1'b0; load_ff <= 1'b0;
                end else if (!armed_ff || ((mode == 3'h4 || rate || sq) && !gate_lvl)) begin
                    if ((rate || sq) && !gate_lvl) out_ff <= 1'b1;
                    if (!armed_ff && mode == 3'h0) cnt_ff <= cnt_ff - 16'h0001;
                    if (mode >= 3'h4 && out_ff == 1'b0) out_ff <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff - 16'h0001;
                    if (mode >= 3'h4) begin
                        out_ff <= ~tc; // [R1]
                        if (!out_ff) armed_ff <= 1'b0;
                        if (!out_ff) out_ff <= 1'b1;
                    end else if (rate) begin
                        out_ff <= ~tc;
                        if (tc) begin cnt_ff <= n_eff; null_ff <= 1'b0; load_ff <= 1'b0; end
                    end else if (sq && tc) begin // [R19]
                        out_ff <= ~half_ff; half_ff <= ~half_ff;
                        cnt_ff <= half_ff ? sq_lo : sq_hi;
                        null_ff <= 1'b0; load_ff <= 1'b0;
                    end else if (mode == 3'h0 && tc) begin
                        out_ff <= 1'b1; armed_ff <= 1'b0;
                    end else if (mode == 3'h1 && tc) begin
                        out_ff <= 1'b1; armed_ff <= 1'b0;
                    end
                end
                if (mode == 3'h1 && gate_rise && !load_ff) begin
                    cnt_ff <= n_eff; armed_ff <= 1'b1; out_ff <= 1'b0;
                end
                if ((rate || sq) && gate_rise) begin
                    cnt_ff <= sq ? sq_hi : n_eff; half_ff <= 1'b1; out_ff <= 1'b1;
                end
            end
            // Placed after the count logic so a count written on a count edge is not lost.
            if (wr) begin // [R4]
                if (acc == ivt_pkg::ACC_LO) init_ff <= {8'h00, wdata};
                else if (acc == ivt_pkg::ACC_HI) init_ff <= {wdata, 8'h00};
                else if (!wr_hi_ff) lo_ff <= wdata;
                else init_ff <= {wdata, lo_ff};
                if (acc == ivt_pkg::ACC_LOHI) wr_hi_ff <= ~wr_hi_ff;
                if (wr_done) begin
                    null_ff <= 1'b1; load_ff <= 1'b1;
                    if (mode == 3'h0) out_ff <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* rtl/ivt_top.sv */
/*
 * Three-channel interval counter with a byte-wide register port and pacer cascade.
 * Assumes host strobes are synchronous to CLK and last one cycle each.
 */
`timescale 1ns/100ps
`default_nettype none
module ivt_top (
    input  wire logic       CLK,      // 10 MHz system clock.
    input  wire logic       RST_N,    // Asynchronous reset, active low.
    input  wire logic [3:0] ADDR,     // Register offset.
    input  wire logic       WR,       // Write strobe, one cycle.
    input  wire logic       RD,       // Read strobe, one cycle.
    input  wire logic [7:0] WDATA,    // Write data.
    input  wire logic       BASE_SEL, // Base clock select: 1 is 1 MHz.
    input  wire logic [2:0] GATE,     // Gate or trigger inputs per channel.
    input  wire logic       CLK0_EN,  // Count enable pulse for counter 0.
    output logic      [7:0] RDATA,    // Read data, registered.
    output logic      [2:0] OUT,      // Channel outputs, registered.
    output logic            PACER     // Conversion trigger pulse.
);
    logic [1:0] rst_sync_ff;
    logic [3:0] div_ff;
    logic [2:0] g1_ff, g2_ff, g3_ff;
    logic [7:0] rdata_ff;
    logic [2:0] out_ff;
    logic       pacer_ff, base_sel_ff;
    logic [7:0] ch_rd [3];
    logic [2:0] ch_out;

    wire rst_n = rst_sync_ff[1];
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) rst_sync_ff <= 2'h0;
        else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end

    // Strap captured after release so the divider never sees a port in reset.
    wire [3:0] div_max = base_sel_ff ? ivt_pkg::SLOW_DIV : ivt_pkg::FAST_DIV; // [R12]
    wire       base_tick = (div_ff == div_max);
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= 4'h0; base_sel_ff <= 1'b0;
            g1_ff <= 3'h0; g2_ff <= 3'h0; g3_ff <= 3'h0;
        end else begin
            base_sel_ff <= BASE_SEL;
            div_ff <= base_tick ? 4'h0 : div_ff + 4'h1;
            g1_ff <= GATE; g2_ff <= g1_ff; g3_ff <= g2_ff; // [R21]
        end
    end
    wire [2:0] g_rise = g2_ff & ~g3_ff; // [R21]

    wire        ctrl_wr = WR & (ADDR == ivt_pkg::OFS_CTRL); // [R18]
    wire [1:0]  sel = WDATA[ivt_pkg::SEL_POS +: 2];
    wire        is_rb = (sel == ivt_pkg::SEL_READBACK); // [R17]
    wire [2:0]  rb_tgt = WDATA[ivt_pkg::RB_TGT +: 3];
    wire        is_cl = (WDATA[ivt_pkg::ACC_POS +: 2] == ivt_pkg::ACC_LATCH);
    wire        rb_cl = ctrl_wr & is_rb & !WDATA[ivt_pkg::RB_CNT_N]; // [R6] [R9]
    wire        rb_sl = ctrl_wr & is_rb & !WDATA[ivt_pkg::RB_STA_N]; // [R7]

    // Counter 1 output falling edge clocks counter 2, so the cascade divides by C1*C2.
    logic out1_d_ff;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) out1_d_ff <= 1'b1;
        else out1_d_ff <= ch_out[1];
    end
    wire [2:0] ticks = {out1_d_ff & ~ch_out[1], base_tick, CLK0_EN}; // [R11] [R22]

    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_ch
            wire hit = (ADDR == ivt_pkg::OFS_CNT0 + 4'(i)); // [R18]
            wire cw  = ctrl_wr & !is_rb & (sel == 2'(i)); // [R3] [R17]
            ivt_channel u_ch (
                .clk       (CLK),
                .rst_n     (rst_n),
                .tick      (ticks[i]),
                .gate_rise (g_rise[i]),
                .gate_lvl  (g2_ff[i]),
                .cfg_we    (cw & !is_cl),
                .cfg_in    (WDATA[5:0]),
                .cnt_latch ((cw & is_cl) | (rb_cl & rb_tgt[i])), // [R6] [R8] [R9]
                .sta_latch (rb_sl & rb_tgt[i]), // [R7]
                .wr        (WR & hit),
                .rd        (RD & hit),
                .wdata     (WDATA),
                .rdata     (ch_rd[i]),
                .out       (ch_out[i])
            );
        end
    endgenerate

    wire [1:0] rsel = 2'(ADDR - ivt_pkg::OFS_CNT0);
    wire       rhit = (ADDR >= ivt_pkg::OFS_CNT0) && (ADDR != ivt_pkg::OFS_CTRL);
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00; out_ff <= 3'h7; pacer_ff <= 1'b1;
        end else begin
            if (RD) rdata_ff <= rhit ? ch_rd[rsel] : 8'h00; // [R5]
            out_ff <= ch_out;
            pacer_ff <= ch_out[2]; // [R22]
        end
    end
    assign RDATA = rdata_ff;
    assign OUT = out_ff;
    assign PACER = pacer_ff;
endmodule
`default_nettype wire

/* verification/ivt_top_asserts.sv */
/* Port-level assertions for the three-channel interval counter, bound to ivt_top.
   Assumes registered RDATA and OUT and one-cycle WR and RD strobes. */
`timescale 1ns/100ps
`default_nettype none
module ivt_top_asserts (
    input wire logic       CLK,     // System clock.
    input wire logic       RST_N,   // Reset, active low.
    input wire logic [3:0] ADDR,    // Register offset.
    input wire logic       WR,      // Write strobe.
    input wire logic       RD,      // Read strobe.
    input wire logic [7:0] WDATA,   // Write data.
    input wire logic       CLK0_EN, // Counter 0 count pulse.
    input wire logic [7:0] RDATA,   // Read data.
    input wire logic [2:0] OUT,     // Channel outputs.
    input wire logic       PACER    // Conversion trigger.
);
    logic [5:0] cfg0_ff;
    wire        ctl_wr  = WR && ADDR == ivt_pkg::OFS_CTRL;
    wire        cfg0_we = ctl_wr && WDATA[7:6] == 2'h0 && WDATA[5:4] != ivt_pkg::ACC_LATCH;
    wire        mode5   = cfg0_ff[3:1] == ivt_pkg::MODE_HWSTROBE;

    // Counter 0 mode is shadowed here so the strobe checks only apply in that mode.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) cfg0_ff <= ivt_pkg::CFG_RESET;
        else if (cfg0_we) cfg0_ff <= WDATA[5:0];
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence sta_latch0;
        ctl_wr && WDATA[7:6] == ivt_pkg::SEL_READBACK && !WDATA[ivt_pkg::RB_STA_N]
            && WDATA[ivt_pkg::RB_TGT];
    endsequence
    sequence rd_cnt0;
        RD && ADDR == ivt_pkg::OFS_CNT0;
    endsequence

    AST_IDLE_AT_RESET: assert property ($rose(RST_N) |-> OUT == 3'h7 && PACER)
        else $error("outputs not idle at reset release");
    AST_PACER_IS_OUT2: assert property (PACER == OUT[2])
        else $error("pacer differs from counter 2 output");
    AST_RDATA_HOLDS: assert property (!$past(RD) |-> $stable(RDATA))
        else $error("read data changed without a read");
    AST_UNMAPPED_ZERO: assert property (RD && ADDR < ivt_pkg::OFS_CNT0 |=> RDATA == 8'h00)
        else $error("unmapped read not zero");
    AST_CTRL_NOT_READ: assert property (RD && ADDR == ivt_pkg::OFS_CTRL |=> RDATA == 8'h00)
        else $error("control word read not zero");
    AST_STROBE_ONE_CLK: assert property (mode5 && CLK0_EN && $fell(OUT[0]) |=> OUT[0])
        else $error("strobe longer than one count clock");
    AST_STROBE_ARMED_HIGH: assert property (cfg0_we && WDATA[3:1] == ivt_pkg::MODE_HWSTROBE
        |-> ##[1:3] OUT[0])
        else $error("output not high after strobe mode set");
    AST_STATUS_FIELDS: assert property (sta_latch0 ##2 rd_cnt0 |=> RDATA[5:0] == cfg0_ff)
        else $error("status byte fields wrong");
endmodule
bind ivt_top ivt_top_asserts chk (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WR(WR), .RD(RD),
    .WDATA(WDATA), .CLK0_EN(CLK0_EN), .RDATA(RDATA), .OUT(OUT), .PACER(PACER));
`default_nettype wire

/* verification/interval_timer_pacer_tb.sv */
/* Self-checking bench for the interval counter with pacer cascade.
   Assumes the checker is bound separately; inputs change 1 ns after CLK rises. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module interval_timer_pacer_tb;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic       base_sel = 1'b0;
    logic [2:0] gate = 3'h6;
    logic       clk0_en = 1'b0;
    logic [7:0] rdata;
    logic [2:0] out;
    logic       pacer;
    wire  [3:0] mon = {pacer, out};
    int         error_cnt = 0;
    int         checked = 0;
    int         exp_q[$];
    int         n1, n2, v, k, hi, lo, got;

    ivt_top uut (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WR(wr), .RD(rd), .WDATA(wdata),
        .BASE_SEL(base_sel), .GATE(gate), .CLK0_EN(clk0_en), .RDATA(rdata), .OUT(out),
        .PACER(pacer));

    always #50 clk = ~clk;

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk) #1;
        wr = 1'b0;
        @(posedge clk) #1;
    endtask
    // The idle cycle after each read keeps RD from being lowered and raised in one step.
    task automatic rd_chk(input logic [3:0] a, input string nm, input logic [7:0] m);
        int e;
        addr = a;
        rd = 1'b1;
        @(posedge clk) #1;
        rd = 1'b0;
        e = exp_q.pop_front();
        `CHK(nm, e[7:0] & m, rdata & m)
        @(posedge clk) #1;
    endtask
    task automatic pulse0(input int n);
        repeat (n) begin
            clk0_en = 1'b1;
            @(posedge clk) #1;
            clk0_en = 1'b0;
            @(posedge clk) #1;
        end
    endtask
    task automatic run_to(input int b, input logic lvl, output int n);
        n = 0;
        while (mon[b] !== lvl && n < 20000) begin
            @(posedge clk) #1;
            n++;
        end
    endtask
    task automatic meas(input int b, output int h, output int l);
        int x;
        run_to(b, 1'b0, x);
        run_to(b, 1'b1, x);
        run_to(b, 1'b0, h);
        run_to(b, 1'b1, l);
    endtask

    initial begin
        #(100 * 40000);
        error_cnt++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        final_report();
    end

    initial begin
        void'($urandom(32'hF7C7));
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge clk) #1;
        `CHK("reset outputs", 4'hF, mon)
        for (int i = 0; i < 6; i++) begin
            exp_q.push_back(0);
            rd_chk((i == 5) ? 4'hF : 4'($urandom_range(11, 0)), "unmapped", 8'hFF);
        end
        $display("test unmapped reads done");
        v = $urandom_range(16'hFFFF, 16'h0100);
        k = $urandom_range(6, 2);
        wr_reg(4'hF, 8'h30);
        wr_reg(4'hC, 8'(v));
        wr_reg(4'hC, 8'(v >> 8));
        pulse0(k);
        wr_reg(4'hF, 8'h00);
        pulse0(3);
        exp_q.push_back(v - k + 1);
        exp_q.push_back((v - k + 1) >> 8);
        rd_chk(4'hC, "latched low", 8'hFF);
        rd_chk(4'hC, "latched high", 8'hFF);
        wr_reg(4'hF, 8'hC2);
        exp_q.push_back(8'h30);
        exp_q.push_back(v - k - 2);
        exp_q.push_back((v - k - 2) >> 8);
        rd_chk(4'hC, "status byte", 8'hBF);
        rd_chk(4'hC, "readback low", 8'hFF);
        rd_chk(4'hC, "readback high", 8'hFF);
        wr_reg(4'hF, 8'hDA);
        pulse0(2);
        exp_q = '{v - k - 2, (v - k - 2) >> 8, 0, 0};
        rd_chk(4'hC, "multi latch low", 8'hFF);
        rd_chk(4'hC, "multi latch high", 8'hFF);
        // Counter 2 has seen no count edge yet, so latched and live values are both zero.
        rd_chk(4'hE, "multi latch ch2", 8'hFF);
        rd_chk(4'hE, "live ch2", 8'hFF);
        $display("test latch and readback done");
        v = $urandom_range(8, 3);
        wr_reg(4'hF, 8'h3A);
        wr_reg(4'hC, 8'(v));
        wr_reg(4'hC, 8'h00);
        clk0_en = 1'b1;
        run_to(0, 1'b0, got);
        `CHK("no strobe before trigger", 20000, got)
        for (int i = 0; i < 2; i++) begin
            gate[0] = 1'b1;
            run_to(0, 1'b0, hi);
            run_to(0, 1'b1, lo);
            `CHK("trigger delay in range", 1'b1, hi >= v && hi <= v + 8)
            `CHK("strobe width", 1, lo)
            gate[0] = 1'b0;
            repeat (4) @(posedge clk) #1;
        end
        // Software strobe: counting starts on load and needs the gate high.
        gate[0] = 1'b1;
        wr_reg(4'hF, 8'h38);
        wr_reg(4'hC, 8'(v));
        wr_reg(4'hC, 8'h00);
        run_to(0, 1'b0, hi);
        run_to(0, 1'b1, lo);
        `CHK("soft strobe delay in range", 1'b1, hi >= v && hi <= v + 4)
        `CHK("soft strobe width", 1, lo)
        clk0_en = 1'b0;
        $display("test triggered strobe done");
        n1 = 2 * $urandom_range(7, 1) + 1;
        n2 = 2 * $urandom_range(3, 1);
        wr_reg(4'hF, 8'h76);
        wr_reg(4'hF, 8'hB6);
        wr_reg(4'hD, 8'(n1));
        wr_reg(4'hD, 8'h00);
        wr_reg(4'hE, 8'(n2));
        wr_reg(4'hE, 8'h00);
        meas(1, hi, lo);
        `CHK("odd high length", (n1 + 1) / 2, hi)
        `CHK("odd low length", (n1 - 1) / 2, lo)
        for (int s = 0; s < 2; s++) begin
            base_sel = 1'(s);
            meas(3, hi, lo);
            meas(3, hi, lo);
            `CHK("pacer high", (s ? 10 : 1) * n1 * n2 / 2, hi)
            `CHK("pacer low", (s ? 10 : 1) * n1 * n2 / 2, lo)
        end
        $display("test pacer cascade done");
        final_report();
    end
endmodule
`default_nettype wire
